// ### include/spcd_pkg.sv
`default_nettype none
package spcd_pkg;

	// ---------------------------------------------------------------
	// instruction codes
	// ---------------------------------------------------------------
	localparam logic [7:0] OP_READ_IDENT     = 8'h9F;
	localparam logic [7:0] OP_READ_DISCOVERY = 8'h5A;
	localparam logic [7:0] OP_READ_STAT_ONE  = 8'h05;
	localparam logic [7:0] OP_READ_STAT_TWO  = 8'h07;
	localparam logic [7:0] OP_READ_CFG_ONE   = 8'h35;
	localparam logic [7:0] OP_READ_CFG_TWO   = 8'h15;
	localparam logic [7:0] OP_READ_CFG_THREE = 8'h33;
	localparam logic [7:0] OP_WRITE_STAT_CFG = 8'h01;
	localparam logic [7:0] OP_NV_WRITE_EN    = 8'h06;
	localparam logic [7:0] OP_VOL_WRITE_EN   = 8'h50;
	localparam logic [7:0] OP_ENTER_WIDE     = 8'hB7;
	localparam logic [7:0] OP_EXIT_WIDE      = 8'hE9;
	localparam logic [7:0] OP_LEARN_READ     = 8'h41;
	localparam logic [7:0] OP_LEARN_STORE_NV = 8'h43;
	localparam logic [7:0] OP_LEARN_STORE_V  = 8'h4A;

	// ---------------------------------------------------------------
	// host clock ceilings in MHz, for the bench only
	// ---------------------------------------------------------------
	localparam int MAX_MHZ_IDENT     = 108;
	localparam int MAX_MHZ_DISCOVERY = 133;
	localparam int MAX_MHZ_CFG_READ  = 108;
	localparam int MAX_MHZ_WRITE_EN  = 133;

	// ---------------------------------------------------------------
	// framing
	// ---------------------------------------------------------------
	localparam logic [2:0] BIT_LAST         = 3'h7;
	localparam logic [2:0] BIT_FIRST        = 3'h0;
	localparam logic [1:0] ADDR_NARROW_LAST = 2'h2;
	localparam logic [1:0] ADDR_WIDE_LAST   = 2'h3;
	localparam logic [2:0] WRR_BYTES        = 3'h4;
	localparam int         ADDR_LEN_BIT     = 0;
	localparam logic [1:0] IDX_MAX          = 2'h3;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_STAT_ONE  = 8'h00;
	localparam logic [7:0] RST_STAT_TWO  = 8'h00;
	localparam logic [7:0] RST_CFG_ONE   = 8'h00;
	localparam logic [7:0] RST_CFG_TWO   = 8'h00;
	localparam logic [7:0] RST_CFG_THREE = 8'h00;
	localparam logic [7:0] RST_LEARN     = 8'h34;
	// select pin idles high; its synchroniser must reset to that level
	localparam logic       SEL_IDLE      = 1'b1;

	// identification bytes: values are arbitrary
	localparam logic [7:0] ID_BYTE0 = 8'hA5;
	localparam logic [7:0] ID_BYTE1 = 8'h5C;
	localparam logic [7:0] ID_BYTE2 = 8'h19;

	// discovery table fill seed: value is arbitrary
	localparam logic [7:0] TBL_SEED = 8'h3C;

	// one-hot command phases
	typedef enum logic [5:0] {
		ST_OPC    = 6'h01,
		ST_ADDR   = 6'h02,
		ST_DUMMY  = 6'h04,
		ST_OUT    = 6'h08,
		ST_IN     = 6'h10,
		ST_IGNORE = 6'h20
	} spcd_state_t;

endpackage
`default_nettype wire

// ### include/spcd_tbl_if.sv
`default_nettype none
interface spcd_tbl_if;
	logic [7:0] addr;
	logic [7:0] rdata;
	modport reader (output addr, input rdata);
	modport table_side (input addr, output rdata);
endinterface
`default_nettype wire

// ### hdl/spcd_sync.sv
`default_nettype none
module spcd_sync #(
	// level held in reset; set to the pin's idle level so no false edge follows release
	parameter logic RST_VAL = 1'b0
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic nrst,
	// pin level in, synchronised level out
	input  wire logic din,
	output logic      dout
);
	import spcd_pkg::*;

	logic meta_ff;

	// two stages; only the second is read outside
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			meta_ff <= RST_VAL;
			dout    <= RST_VAL;
		end else begin
			meta_ff <= din;
			dout    <= meta_ff;
		end
	end
endmodule
`default_nettype wire

// ### hdl/spcd_table.sv
`default_nettype none
module spcd_table (
	// clock and reset
	input  wire logic mclk,
	input  wire logic nrst,
	// lookup port
	spcd_tbl_if.table_side tbl
);
	import spcd_pkg::*;

	// ---------------------------------------------------------------
	// read-only discovery table, registered read
	// ---------------------------------------------------------------
	logic [7:0] rom [256];

	always_comb begin
		for (int i = 0; i < 256; i++) begin
			rom[i] = TBL_SEED ^ 8'(i);
		end
	end

	// registered output keeps the long decode off the shift path
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			tbl.rdata <= 8'h00;
		end else begin
			tbl.rdata <= rom[tbl.addr];
		end
	end
endmodule
`default_nettype wire

// ### hdl/spcd_decoder.sv
// Operation
// - 0x9F returns identification bytes, no address, host clock up to 108 MHz.
// - 0x5A reads discovery table after 3 or 4 address bytes, up to 133 MHz.
// - 0x05 returns status one, 0x07 status two, no address.
// - 0x35, 0x15, 0x33 return config one, two, three; host stays at 108 MHz.
// - 0x01 writes status one then config one, two, three; no address.
// - 0x06 enables a later non-volatile change, up to 133 MHz.
// - 0x50 enables only a following volatile register update.
// - enter-wide instruction makes legacy addressed instructions take four bytes.
// - 0xE9 returns legacy addressed instructions to three address bytes.
// - 0x41 outputs the data learning pattern.
// - 0x43 stores supplied pattern into non-volatile learning register.
// - 0x4A loads supplied pattern into volatile learning register.
// - address-length bit set means legacy instructions carry 32-bit address.
// - select low starts, high ends a command; misaligned end rejects it.
`default_nettype none
module spcd_decoder (
	// clock and reset
	input  wire logic  mclk,
	input  wire logic  nrst,
	// serial pins from host
	input  wire logic  sel_n,
	input  wire logic  sck,
	input  wire logic  si,
	// serial output pin
	output logic       so_ff,
	output logic       so_oe_ff,
	// status seen by the core
	output logic       wide_addr_ff,
	output logic       wel_nv_ff,
	output logic       wel_v_ff,
	output logic       reject_ff,
	output logic [7:0] learn_nv_ff
);
	import spcd_pkg::*;

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic sel_n_s, sck_s, si_s;
	logic sel_d_ff, sck_d_ff;

	spcd_sync #(.RST_VAL(SEL_IDLE)) u_sync_sel (.mclk(mclk), .nrst(nrst), .din(sel_n), .dout(sel_n_s));
	spcd_sync u_sync_sck (.mclk(mclk), .nrst(nrst), .din(sck),   .dout(sck_s));
	spcd_sync u_sync_si  (.mclk(mclk), .nrst(nrst), .din(si),    .dout(si_s));

	// edge history on synchronised levels only
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sel_d_ff <= SEL_IDLE;
			sck_d_ff <= 1'b0;
		end else begin
			sel_d_ff <= sel_n_s;
			sck_d_ff <= sck_s;
		end
	end

	logic sck_rise, sck_fall, sel_end, active;
	assign active   = !sel_n_s;
	assign sck_rise = active && sck_s && !sck_d_ff;
	assign sck_fall = active && !sck_s && sck_d_ff;
	assign sel_end  = sel_n_s && !sel_d_ff;

	// ---------------------------------------------------------------
	// bit framing
	// ---------------------------------------------------------------
	spcd_state_t state_ff;
	logic [2:0]  bit_cnt_ff;
	logic [6:0]  in_sh_ff;
	logic [7:0]  cmd_ff;
	logic        cmd_valid_ff;
	logic        byte_done;
	logic [7:0]  byte_in;

	assign byte_done = sck_rise && (bit_cnt_ff == BIT_LAST);
	assign byte_in   = {in_sh_ff, si_s};

	// mode 0: sample on rising edge; select high clears framing
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			bit_cnt_ff <= BIT_FIRST;
			in_sh_ff   <= 7'h00;
		end else if (!active) begin
			bit_cnt_ff <= BIT_FIRST;
		end else if (sck_rise) begin
			bit_cnt_ff <= bit_cnt_ff + 3'h1;
			in_sh_ff   <= byte_in[6:0];
		end
	end

	// ---------------------------------------------------------------
	// command phases
	// ---------------------------------------------------------------
	logic [1:0] addr_cnt_ff;
	logic [1:0] addr_last;
	logic [1:0] out_idx_ff;
	logic [2:0] in_cnt_ff;
	logic [7:0] stage_ff [WRR_BYTES];
	logic [7:0] cfg_two_ff;
	logic       known_op;

	// address length follows the volatile length bit
	assign addr_last = cfg_two_ff[ADDR_LEN_BIT] ? ADDR_WIDE_LAST : ADDR_NARROW_LAST;

	always_comb begin
		unique case (byte_in)
			OP_READ_IDENT, OP_READ_DISCOVERY, OP_READ_STAT_ONE, OP_READ_STAT_TWO,
			OP_READ_CFG_ONE, OP_READ_CFG_TWO, OP_READ_CFG_THREE, OP_WRITE_STAT_CFG,
			OP_NV_WRITE_EN, OP_VOL_WRITE_EN, OP_ENTER_WIDE, OP_EXIT_WIDE,
			OP_LEARN_READ, OP_LEARN_STORE_NV, OP_LEARN_STORE_V: known_op = 1'b1;
			default: known_op = 1'b0;
		endcase
	end

	// opcode decode and phase walk
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_ff     <= ST_OPC;
			cmd_ff       <= 8'h00;
			cmd_valid_ff <= 1'b0;
			addr_cnt_ff  <= 2'h0;
		end else if (!active) begin
			state_ff     <= ST_OPC;
			cmd_valid_ff <= 1'b0;
			addr_cnt_ff  <= 2'h0;
		end else if (byte_done) begin
			unique case (state_ff)
				ST_OPC: begin
					cmd_ff       <= byte_in;
					cmd_valid_ff <= known_op;
					unique case (byte_in)
						OP_READ_IDENT, OP_READ_STAT_ONE, OP_READ_STAT_TWO, OP_READ_CFG_ONE,
						OP_READ_CFG_TWO, OP_READ_CFG_THREE,
						OP_LEARN_READ:     state_ff <= ST_OUT;
						OP_READ_DISCOVERY: state_ff <= ST_ADDR;
						OP_WRITE_STAT_CFG, OP_LEARN_STORE_NV,
						OP_LEARN_STORE_V:  state_ff <= ST_IN;
						default:           state_ff <= ST_IGNORE;
					endcase
				end
				ST_ADDR: begin
					addr_cnt_ff <= addr_cnt_ff + 2'h1;
					if (addr_cnt_ff == addr_last) begin
						state_ff <= ST_DUMMY;
					end
				end
				ST_DUMMY:  state_ff <= ST_OUT;
				ST_OUT:    state_ff <= ST_OUT;
				ST_IN:     state_ff <= ST_IN;
				ST_IGNORE: state_ff <= ST_IGNORE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// incoming data staging
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			in_cnt_ff <= 3'h0;
			for (int i = 0; i < WRR_BYTES; i++) begin
				stage_ff[i] <= 8'h00;
			end
		end else if (!active) begin
			in_cnt_ff <= 3'h0;
		end else if (byte_done && state_ff == ST_IN && in_cnt_ff < WRR_BYTES) begin
			stage_ff[in_cnt_ff[1:0]] <= byte_in;
			in_cnt_ff                <= in_cnt_ff + 3'h1;
		end
	end

	// ---------------------------------------------------------------
	// registers updated at a clean end of command
	// ---------------------------------------------------------------
	logic [7:0] stat_one_ff, stat_two_ff, cfg_one_ff, cfg_three_ff, learn_v_ff;
	logic       commit, wel_any;

	assign commit  = sel_end && cmd_valid_ff && (bit_cnt_ff == BIT_FIRST);
	assign wel_any = wel_nv_ff || wel_v_ff;
	assign wide_addr_ff = cfg_two_ff[ADDR_LEN_BIT];

	// status and config; one write-stat-config fills status one, then config one, two, three in order
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			stat_one_ff  <= RST_STAT_ONE;
			stat_two_ff  <= RST_STAT_TWO;
			cfg_one_ff   <= RST_CFG_ONE;
			cfg_two_ff   <= RST_CFG_TWO;
			cfg_three_ff <= RST_CFG_THREE;
		end else if (commit) begin
			if (cmd_ff == OP_WRITE_STAT_CFG && wel_any) begin
				if (in_cnt_ff > 3'h0) stat_one_ff  <= stage_ff[0];
				if (in_cnt_ff > 3'h1) cfg_one_ff   <= stage_ff[1];
				if (in_cnt_ff > 3'h2) cfg_two_ff   <= stage_ff[2];
				if (in_cnt_ff > 3'h3) cfg_three_ff <= stage_ff[3];
			end else if (cmd_ff == OP_ENTER_WIDE) begin
				cfg_two_ff[ADDR_LEN_BIT] <= 1'b1;
			end else if (cmd_ff == OP_EXIT_WIDE) begin
				cfg_two_ff[ADDR_LEN_BIT] <= 1'b0;
			end
		end
	end

	// write enables; a completed write-stat-config or non-volatile learning store consumes them
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wel_nv_ff <= 1'b0;
			wel_v_ff  <= 1'b0;
		end else if (commit) begin
			unique case (cmd_ff)
				OP_NV_WRITE_EN:  wel_nv_ff <= 1'b1;
				OP_VOL_WRITE_EN: wel_v_ff  <= 1'b1;
				OP_WRITE_STAT_CFG, OP_LEARN_STORE_NV: begin
					wel_nv_ff <= 1'b0;
					wel_v_ff  <= 1'b0;
				end
				default: begin
					wel_nv_ff <= wel_nv_ff;
					wel_v_ff  <= wel_v_ff;
				end
			endcase
		end
	end

	// learning pattern; the stored copy needs the non-volatile enable
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			learn_v_ff  <= RST_LEARN;
			learn_nv_ff <= RST_LEARN;
		end else if (commit && in_cnt_ff != 3'h0) begin
			if (cmd_ff == OP_LEARN_STORE_V) begin
				learn_v_ff <= stage_ff[0];
			end
			if (cmd_ff == OP_LEARN_STORE_NV && wel_nv_ff) begin
				learn_nv_ff <= stage_ff[0];
			end
		end
	end

	// misaligned end is flagged for one cycle and changes nothing
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			reject_ff <= 1'b0;
		end else begin
			reject_ff <= sel_end && (bit_cnt_ff != BIT_FIRST);
		end
	end

	// ---------------------------------------------------------------
	// output path
	// ---------------------------------------------------------------
	spcd_tbl_if tbl ();
	spcd_table  u_table (.mclk(mclk), .nrst(nrst), .tbl(tbl));

	logic [7:0] tbl_addr_ff, out_byte;
	logic [6:0] out_sh_ff;

	assign tbl.addr = tbl_addr_ff;

	// last address byte is the table offset; table is only 256 bytes
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			tbl_addr_ff <= 8'h00;
			out_idx_ff  <= 2'h0;
		end else if (!active) begin
			out_idx_ff <= 2'h0;
		end else if (byte_done && state_ff == ST_ADDR) begin
			tbl_addr_ff <= byte_in;
		end else if (byte_done && state_ff == ST_OUT) begin
			tbl_addr_ff <= tbl_addr_ff + 8'h01;
			if (out_idx_ff != IDX_MAX) out_idx_ff <= out_idx_ff + 2'h1;
		end
	end

	// byte to send; register reads repeat until select rises
	always_comb begin
		unique case (cmd_ff)
			OP_READ_IDENT: begin
				unique case (out_idx_ff)
					2'h0:    out_byte = ID_BYTE0;
					2'h1:    out_byte = ID_BYTE1;
					2'h2:    out_byte = ID_BYTE2;
					default: out_byte = 8'h00;
				endcase
			end
			OP_READ_DISCOVERY: out_byte = tbl.rdata;
			OP_READ_STAT_ONE:  out_byte = stat_one_ff;
			OP_READ_STAT_TWO:  out_byte = stat_two_ff;
			OP_READ_CFG_ONE:   out_byte = cfg_one_ff;
			OP_READ_CFG_TWO:   out_byte = cfg_two_ff;
			OP_READ_CFG_THREE: out_byte = cfg_three_ff;
			OP_LEARN_READ:     out_byte = learn_v_ff;
			default:           out_byte = 8'h00;
		endcase
	end

	// shift out on falling edge, msb first
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			so_ff     <= 1'b0;
			out_sh_ff <= 7'h00;
		end else if (sck_fall && state_ff == ST_OUT) begin
			if (bit_cnt_ff == BIT_FIRST) begin
				so_ff     <= out_byte[7];
				out_sh_ff <= out_byte[6:0];
			end else begin
				so_ff     <= out_sh_ff[6];
				out_sh_ff <= {out_sh_ff[5:0], 1'b0};
			end
		end
	end

	// driver on only while answering inside a command
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			so_oe_ff <= 1'b0;
		end else begin
			so_oe_ff <= active && state_ff == ST_OUT;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	chk_oe_only_out: assert property (@(posedge mclk) disable iff (!nrst)
		so_oe_ff |-> $past(state_ff) == ST_OUT) else $error("output driven outside answer phase");
	chk_read_goes_out: assert property (@(posedge mclk) disable iff (!nrst)
		(byte_done && state_ff == ST_OPC && (byte_in == OP_READ_STAT_ONE || byte_in == OP_LEARN_READ))
		|=> state_ff == ST_OUT ##1 so_oe_ff) else $error("register read did not answer");
	chk_addr_len: assert property (@(posedge mclk) disable iff (!nrst)
		(byte_done && state_ff == ST_ADDR && addr_cnt_ff != addr_last) |=> state_ff == ST_ADDR)
		else $error("address phase ended early");
	chk_enter_wide: assert property (@(posedge mclk) disable iff (!nrst)
		(commit && cmd_ff == OP_ENTER_WIDE) |=> wide_addr_ff) else $error("wide address not entered");
	chk_exit_wide: assert property (@(posedge mclk) disable iff (!nrst)
		(commit && cmd_ff == OP_EXIT_WIDE) |=> !wide_addr_ff) else $error("wide address not left");
	chk_misalign_reject: assert property (@(posedge mclk) disable iff (!nrst)
		(sel_end && bit_cnt_ff != BIT_FIRST) |=> reject_ff && $stable(stat_one_ff) && $stable(wel_nv_ff))
		else $error("misaligned command not rejected");
	chk_wrr_locked: assert property (@(posedge mclk) disable iff (!nrst)
		(commit && cmd_ff == OP_WRITE_STAT_CFG && !wel_any) |=> $stable(stat_one_ff) && $stable(cfg_one_ff))
		else $error("register write without enable");
	chk_enables_set: assert property (@(posedge mclk) disable iff (!nrst)
		(commit && cmd_ff == OP_NV_WRITE_EN) |=> wel_nv_ff [*1] ##0 !reject_ff) else $error("enable not set");
	chk_vol_enable: assert property (@(posedge mclk) disable iff (!nrst)
		(commit && cmd_ff == OP_VOL_WRITE_EN) |=> wel_v_ff) else $error("volatile enable not set");
	chk_learn_store: assert property (@(posedge mclk) disable iff (!nrst)
		(commit && cmd_ff == OP_LEARN_STORE_V && in_cnt_ff != 3'h0) |=> learn_v_ff == $past(stage_ff[0]))
		else $error("learning pattern not loaded");
	chk_unknown_quiet: assert property (@(posedge mclk) disable iff (!nrst)
		(byte_done && state_ff == ST_OPC && !known_op) |=> (state_ff == ST_IGNORE && !cmd_valid_ff) [*2])
		else $error("unknown instruction not ignored");
endmodule
`default_nettype wire

// ### tb/spcd_host.sv
`default_nettype none
module spcd_host (
	// clock
	input  wire logic mclk,
	// pins toward the device
	output var logic  sel_n,
	output var logic  sck,
	output var logic  si,
	// answer from the device
	input  wire logic so
);
	timeunit 1ns;
	timeprecision 1ns;

	// ------------------------------------------------
	// host pins
	// ------------------------------------------------
	// sck half period in mclk cycles: 200 ns, far below every ceiling
	localparam int HALF = 4;

	initial begin
		sel_n = 1'b1;
		sck   = 1'b0;
		si    = 1'b0;
	end

	// idle data line toggles so a stale level never looks valid
	always @(posedge mclk) begin
		if (sel_n) begin
			si <= ~si;
		end
	end

	// one framed transfer, msb first; sck idles low between frames
	task automatic frame(input logic [63:0] tx, input int nbits, output logic [63:0] rx);
		int i;
		rx = 64'h0;
		@(posedge mclk);
		sel_n <= 1'b0;
		repeat (HALF) @(posedge mclk);
		for (i = 0; i < nbits; i++) begin
			sck <= 1'b0;
			si  <= tx[63 - (i % 64)];
			repeat (HALF) @(posedge mclk);
			sck <= 1'b1;
			// answer bit is settled after the rise and holds past the next fall
			repeat (2) @(negedge mclk);
			rx = {rx[62:0], so};
			repeat (HALF - 1) @(posedge mclk);
		end
		sck <= 1'b0;
		repeat (HALF) @(posedge mclk);
		sel_n <= 1'b1;
		repeat (2 * HALF) @(posedge mclk);
	endtask
endmodule
`default_nettype wire

// ### tb/spcd_decoder_test.sv
`default_nettype none
module spcd_decoder_test;
	timeunit 1ns;
	timeprecision 1ns;
	import spcd_pkg::*;

	// ------------------------------------------------
	// signals and reference state
	// ------------------------------------------------
	logic        mclk, nrst, sel_n, sck, si, so_pin, flip;
	logic        so_ff, so_oe_ff, wide_addr_ff, wel_nv_ff, wel_v_ff, reject_ff;
	logic [7:0]  learn_nv_ff;
	int          fails, n_tests, n_rej, oe_seen;
	int unsigned rs = 6;
	logic [7:0]  m_st1, m_cr1, m_cr2, m_cr3, m_lnv, m_lv;
	logic        m_wnv, m_wv;
	// reads first, so an index below 8 means an answer is due
	logic [7:0]  ops [15];

	spcd_decoder uut (.mclk(mclk), .nrst(nrst), .sel_n(sel_n), .sck(sck), .si(si), .so_ff(so_ff),
		.so_oe_ff(so_oe_ff), .wide_addr_ff(wide_addr_ff), .wel_nv_ff(wel_nv_ff), .wel_v_ff(wel_v_ff),
		.reject_ff(reject_ff), .learn_nv_ff(learn_nv_ff));
	spcd_host host (.mclk(mclk), .sel_n(sel_n), .sck(sck), .si(si), .so(so_pin));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// released answer line shows a changing pattern, not its last bit
	always @(posedge mclk) flip <= ~flip;
	assign so_pin = so_oe_ff ? so_ff : flip;

	// pulse counter and answer-phase watch, sampled mid-cycle
	always @(negedge mclk) begin
		if (reject_ff === 1'b1) n_rej++;
		if (so_oe_ff === 1'b1) oe_seen = 1;
	end

	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	function automatic logic [7:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs[7:0];
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// four answer bytes expected for a read, a = last address byte
	function automatic logic [31:0] answer(input logic [7:0] op, input logic [7:0] a);
		logic [7:0] b;
		case (op)
			OP_READ_IDENT:     return {ID_BYTE0, ID_BYTE1, ID_BYTE2, 8'h00};
			OP_READ_STAT_ONE:  b = m_st1;
			OP_READ_STAT_TWO:  b = RST_STAT_TWO;
			OP_READ_CFG_ONE:   b = m_cr1;
			OP_READ_CFG_TWO:   b = m_cr2;
			OP_READ_CFG_THREE: b = m_cr3;
			OP_LEARN_READ:     b = m_lv;
			default:           return {TBL_SEED ^ a, TBL_SEED ^ (a + 8'h01), TBL_SEED ^ (a + 8'h02), TBL_SEED ^ (a + 8'h03)};
		endcase
		return {4{b}};
	endfunction

	// reference effect of a whole frame at select rise
	task automatic apply(input logic [7:0] op, input logic [55:0] d, input int nin);
		case (op)
			OP_NV_WRITE_EN:   m_wnv = 1'b1;
			OP_VOL_WRITE_EN:  m_wv = 1'b1;
			OP_ENTER_WIDE:    m_cr2[0] = 1'b1;
			OP_EXIT_WIDE:     m_cr2[0] = 1'b0;
			OP_LEARN_STORE_V: m_lv = d[55:48];
			OP_WRITE_STAT_CFG, OP_LEARN_STORE_NV: begin
				if (op == OP_LEARN_STORE_NV && m_wnv) m_lnv = d[55:48];
				if (op == OP_WRITE_STAT_CFG && (m_wnv || m_wv)) begin
					if (nin > 0) m_st1 = d[55:48];
					if (nin > 1) m_cr1 = d[47:40];
					if (nin > 2) m_cr2 = d[39:32];
					if (nin > 3) m_cr3 = d[31:24];
				end
				m_wnv = 1'b0;
				m_wv = 1'b0;
			end
			default: ;
		endcase
	endtask

	// frame of op, nin bytes in, nout bytes out, xbits stray bits
	task automatic cmd(input logic [7:0] op, input logic [55:0] dat, input int nin, input int nout, input int xbits);
		logic [63:0] rx;
		logic [31:0] mask;
		logic [7:0]  a;
		int          r0, i;
		r0 = n_rej;
		oe_seen = 0;
		a = 8'(dat >> (8 * (8 - nin)));
		mask = 32'hFFFFFFFF >> (8 * (4 - nout));
		host.frame({op, dat}, 8 * (1 + nin + nout) + xbits, rx);
		for (i = 0; i < 8 && so_oe_ff !== 1'b0; i++) @(posedge mclk);
		if (so_oe_ff !== 1'b0) begin
			fails++;
			stop_test();
		end
		if (xbits == 0) apply(op, dat, nin);
		if (nout > 0) check(rx[31:0] & mask, answer(op, a) >> (8 * (4 - nout)));
		check(32'(wide_addr_ff), 32'(m_cr2[0]));
		check({wel_nv_ff, wel_v_ff}, {m_wnv, m_wv});
		check(learn_nv_ff, m_lnv);
		check(n_rej - r0, 32'(xbits != 0));
		check(oe_seen, 32'(nout > 0));
	endtask

	task automatic read_all();
		int i;
		for (i = 0; i < 7; i++) cmd(ops[i], 56'h0, 0, 4, 0);
	endtask

	task automatic do_reset();
		nrst <= 1'b0;
		{m_st1, m_cr1, m_cr2, m_cr3} = {RST_STAT_ONE, RST_CFG_ONE, RST_CFG_TWO, RST_CFG_THREE};
		{m_lnv, m_lv, m_wnv, m_wv} = {RST_LEARN, RST_LEARN, 2'b00};
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		@(negedge mclk);
		check(learn_nv_ff, RST_LEARN);
		check({wide_addr_ff, wel_nv_ff, wel_v_ff, reject_ff, so_oe_ff}, 5'h00);
	endtask

	// ------------------------------------------------
	// sequence
	// ------------------------------------------------
	initial begin
		int k, idx, nin;
		nrst = 1'b0;
		flip = 1'b0;
		{fails, n_tests, n_rej, oe_seen} = '0;
		ops = '{OP_READ_IDENT, OP_READ_STAT_ONE, OP_READ_STAT_TWO, OP_READ_CFG_ONE, OP_READ_CFG_TWO,
			OP_READ_CFG_THREE, OP_LEARN_READ, OP_READ_DISCOVERY, OP_WRITE_STAT_CFG, OP_NV_WRITE_EN,
			OP_VOL_WRITE_EN, OP_ENTER_WIDE, OP_EXIT_WIDE, OP_LEARN_STORE_NV, OP_LEARN_STORE_V};
		do_reset();
		read_all();
		// table offset wraps past FF
		cmd(OP_READ_DISCOVERY, {rnd(), rnd(), 8'hFE, rnd(), 24'h0}, 4, 4, 0);
		cmd(OP_ENTER_WIDE, 56'h0, 0, 0, 0);
		cmd(OP_READ_DISCOVERY, {rnd(), rnd(), rnd(), 8'h81, rnd(), 16'h0}, 5, 4, 0);
		cmd(OP_READ_CFG_TWO, 56'h0, 0, 4, 0);
		cmd(OP_EXIT_WIDE, 56'h0, 0, 0, 0);
		cmd(OP_WRITE_STAT_CFG, {rnd(), rnd(), rnd(), rnd(), 24'h0}, 4, 0, 0);
		cmd(OP_VOL_WRITE_EN, 56'h0, 0, 0, 0);
		cmd(OP_WRITE_STAT_CFG, {rnd(), rnd(), rnd(), rnd(), 24'h0}, 4, 0, 0);
		read_all();
		cmd(OP_NV_WRITE_EN, 56'h0, 0, 0, 0);
		cmd(OP_WRITE_STAT_CFG, {rnd(), rnd(), 40'h0}, 2, 0, 4);
		cmd(OP_WRITE_STAT_CFG, {rnd(), rnd(), 40'h0}, 2, 0, 0);
		cmd(OP_NV_WRITE_EN, 56'h0, 0, 0, 5);
		cmd(OP_LEARN_STORE_NV, {rnd(), 48'h0}, 1, 0, 0);
		cmd(OP_NV_WRITE_EN, 56'h0, 0, 0, 0);
		cmd(OP_LEARN_STORE_NV, {rnd(), 48'h0}, 1, 0, 0);
		cmd(OP_LEARN_STORE_V, {rnd(), 48'h0}, 1, 0, 0);
		cmd(OP_LEARN_READ, 56'h0, 0, 2, 0);
		// an enable hidden behind an unknown code must not act
		cmd(8'hAB, {OP_NV_WRITE_EN, 48'h0}, 1, 0, 0);
		read_all();
		for (k = 0; k < 16; k++) begin
			idx = rnd() % 15;
			nin = (ops[idx] == OP_WRITE_STAT_CFG) ? 4 : (ops[idx] == OP_READ_DISCOVERY) ? 4 + m_cr2[0] : 0;
			if (ops[idx] == OP_LEARN_STORE_NV || ops[idx] == OP_LEARN_STORE_V) nin = 1;
			cmd(ops[idx], {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()}, nin, idx < 8 ? 4 : 0, 0);
		end
		// second reset in mid-run
		do_reset();
		read_all();
		stop_test();
	end

	initial begin
		repeat (90000) @(posedge mclk);
		fails++;
		stop_test();
	end
endmodule
`default_nettype wire
